// *** amu_booth.sv ***
// constants package and booth-recoded multiplier array of the arith unit
`default_nettype none

package amu_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SLICE_W    = 16;
  localparam int unsigned ACC_W      = 64;
  localparam int unsigned MCAND_W    = DATA_W + 1;
  localparam int unsigned MPLIER_W   = SLICE_W + 1;
  localparam int unsigned PROD_W     = MCAND_W + MPLIER_W;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] DIV_FULL_ITER = 6'h20;
  // iterations skipped per effective dividend width
  localparam logic [CNT_W-1:0] DIV_SKIP_8    = 6'h17;
  localparam logic [CNT_W-1:0] DIV_SKIP_16   = 6'h0f;
  localparam logic [CNT_W-1:0] DIV_SKIP_24   = 6'h07;
  localparam logic [CNT_W-1:0] DIV_SKIP_32   = 6'h00;
  // repeat rates per effective dividend width
  localparam logic [CNT_W-1:0] DIV_REP_8     = 6'h0b;
  localparam logic [CNT_W-1:0] DIV_REP_16    = 6'h12;
  localparam logic [CNT_W-1:0] DIV_REP_24    = 6'h19;
  localparam logic [CNT_W-1:0] DIV_REP_32    = 6'h20;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_PROD        = 4'h1,
    OP_PRODU       = 4'h2,
    OP_ACC_ADD     = 4'h3,
    OP_ACC_ADDU    = 4'h4,
    OP_ACC_SUB     = 4'h5,
    OP_ACC_SUBU    = 4'h6,
    OP_MUL_GPR     = 4'h7,
    OP_DIV         = 4'h8,
    OP_DIVU        = 4'h9,
    OP_READ_TOP    = 4'ha,
    OP_READ_BOTTOM = 4'hb
  } amu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PASS2 = 3'b010,
    ST_DIV   = 3'b100
  } amu_state_t;
endpackage : amu_pkg

module amu_booth
  import amu_pkg::*;
#(
  parameter int unsigned A_W = 33,
  parameter int unsigned B_W = 17
) (
  input  wire logic [A_W-1:0]     mcand_in,
  input  wire logic [B_W-1:0]     mplier_in,
  output logic      [A_W+B_W-1:0] prod_out
);
  localparam int unsigned ND = (B_W + 1) / 2;
  localparam int unsigned PW = A_W + B_W;

  logic [2*ND:0]           yp;
  logic [ND-1:0][A_W:0]    pp;

  // radix-4 digit select, one partial product per two multiplier bits
  function automatic logic [A_W:0] booth_pp(input logic [2:0] d,
                                            input logic [A_W-1:0] a);
    logic [A_W:0] a1;
    logic [A_W:0] a2;
    a1 = {a[A_W-1], a};
    a2 = {a, 1'b0};
    case (d)
      3'b001, 3'b010: booth_pp = a1;
      3'b011:         booth_pp = a2;
      3'b100:         booth_pp = -a2;
      3'b101, 3'b110: booth_pp = -a1;
      default:        booth_pp = '0;
    endcase
  endfunction : booth_pp

  assign yp = {{(2*ND-B_W){mplier_in[B_W-1]}}, mplier_in, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++) begin : g_digit
      assign pp[gi] = booth_pp(yp[2*gi+2 -: 3], mcand_in);
    end
  endgenerate

  always_comb begin
    logic [PW-1:0] sum;
    sum = '0;
    for (int i = 0; i < ND; i++) begin
      sum = sum + ({{(PW-A_W-1){pp[i][A_W]}}, pp[i]} << (2*i));
    end
    prod_out = sum;
  end
endmodule : amu_booth

`default_nettype wire

// *** amu_unit.sv ***
// arith unit: multiply/divide pipeline with accumulator pair
`default_nettype none

module amu_unit
  import amu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              issue_valid_in,
  input  wire amu_op_t           issue_op_in,
  input  wire logic [DATA_W-1:0] source_a_operand_in,
  input  wire logic [DATA_W-1:0] source_b_operand_in,
  output logic                   stall_out,
  output logic [DATA_W-1:0]      acc_top_out,
  output logic [DATA_W-1:0]      acc_bottom_out,
  output logic                   gpr_valid_out,
  output logic [DATA_W-1:0]      gpr_data_out,
  output logic                   read_valid_out,
  output logic [DATA_W-1:0]      read_data_out
);
  amu_state_t         state_reg,  state_next;
  amu_op_t            op_reg,     op_next;
  logic [DATA_W-1:0]  a_reg,      a_next;
  logic [DATA_W-1:0]  b_reg,      b_next;
  logic               sgn_reg,    sgn_next;
  logic [PROD_W-1:0]  part_reg,   part_next;
  logic [ACC_W-1:0]   acc_reg,    acc_next;
  logic [CNT_W-1:0]   cnt_reg,    cnt_next;
  logic [CNT_W-1:0]   iter_reg,   iter_next;
  logic [DATA_W-1:0]  rem_reg,    rem_next;
  logic [DATA_W-1:0]  quo_reg,    quo_next;
  logic [DATA_W-1:0]  dvs_reg,    dvs_next;
  logic               qneg_reg,   qneg_next;
  logic               rneg_reg,   rneg_next;
  logic               gst_v_reg,  gst_v_next;
  logic [DATA_W-1:0]  gst_reg,    gst_next;
  logic               gpr_v_reg,  gpr_v_next;
  logic [DATA_W-1:0]  gpr_d_reg,  gpr_d_next;
  logic               rd_v_reg,   rd_v_next;
  logic [DATA_W-1:0]  rd_d_reg,   rd_d_next;
  logic               stall_reg,  stall_next;

  logic               go;
  logic               in_sgn;
  logic               fits16;
  logic [MCAND_W-1:0] mcand;
  logic [MPLIER_W-1:0] mplier;
  logic [PROD_W-1:0]  prod;
  logic [ACC_W-1:0]   prod_full;

  function automatic logic op_signed(input amu_op_t op);
    op_signed = (op == OP_PROD) || (op == OP_ACC_ADD) ||
                (op == OP_ACC_SUB) || (op == OP_MUL_GPR) || (op == OP_DIV);
  endfunction : op_signed

  function automatic logic op_product_to_acc(input amu_op_t op);
    op_product_to_acc = (op >= OP_PROD) && (op <= OP_MUL_GPR);
  endfunction : op_product_to_acc

  function automatic logic [ACC_W-1:0] sext_prod(input logic [PROD_W-1:0] p);
    sext_prod = {{(ACC_W-PROD_W){p[PROD_W-1]}}, p};
  endfunction : sext_prod

  // one shift-subtract step, returns {remainder, quotient}
  function automatic logic [2*DATA_W-1:0] div_step(
      input logic [DATA_W-1:0] rem, input logic [DATA_W-1:0] quo,
      input logic [DATA_W-1:0] dvs);
    logic [DATA_W:0] r;
    logic            q;
    r = {rem, quo[DATA_W-1]};
    q = (r >= {1'b0, dvs});
    if (q) begin
      r = r - {1'b0, dvs};
    end
    div_step = {r[DATA_W-1:0], quo[DATA_W-2:0], q};
  endfunction : div_step

  // skip count from how far the dividend is pure sign extension
  function automatic logic [CNT_W-1:0] div_skip(input logic [DATA_W-1:0] a,
                                                input logic s);
    if (s ? (&a[31:7] || ~|a[31:7]) : ~|a[31:8]) begin
      div_skip = DIV_SKIP_8;
    end else if (s ? (&a[31:15] || ~|a[31:15]) : ~|a[31:16]) begin
      div_skip = DIV_SKIP_16;
    end else if (s ? (&a[31:23] || ~|a[31:23]) : ~|a[31:24]) begin
      div_skip = DIV_SKIP_24;
    end else begin
      div_skip = DIV_SKIP_32;
    end
  endfunction : div_skip

  function automatic logic [CNT_W-1:0] div_rep(input logic [CNT_W-1:0] skip);
    case (skip)
      DIV_SKIP_8:  div_rep = DIV_REP_8;
      DIV_SKIP_16: div_rep = DIV_REP_16;
      DIV_SKIP_24: div_rep = DIV_REP_24;
      default:     div_rep = DIV_REP_32;
    endcase
  endfunction : div_rep

  // issues are taken only when idle; stall_out mirrors the busy state
  assign go     = issue_valid_in && (state_reg == ST_IDLE);
  assign in_sgn = op_signed(issue_op_in);
  // only operand b, read signed or unsigned per the op, decides the pass count
  assign fits16 = in_sgn ? (&source_b_operand_in[31:15] ||
                            ~|source_b_operand_in[31:15])
                         : ~|source_b_operand_in[31:16];

  always_comb begin
    if (state_reg == ST_PASS2) begin
      mcand  = {sgn_reg & a_reg[31], a_reg};
      mplier = {sgn_reg & b_reg[31], b_reg[31:16]};
    end else begin
      mcand  = {in_sgn & source_a_operand_in[31], source_a_operand_in};
      // low slice of a two-pass product is always unsigned
      mplier = {in_sgn & fits16 & source_b_operand_in[15],
                source_b_operand_in[15:0]};
    end
  end

  amu_booth #(
    .A_W (MCAND_W),
    .B_W (MPLIER_W)
  ) u_amu_booth (
    .mcand_in  (mcand),
    .mplier_in (mplier),
    .prod_out  (prod)
  );

  assign prod_full = (state_reg == ST_PASS2)
                   ? sext_prod(part_reg) + (sext_prod(prod) << SLICE_W)
                   : sext_prod(prod);

  always_comb begin
    logic           fin_mul;
    amu_op_t        fop;
    logic [CNT_W-1:0] skip;
    logic [DATA_W-1:0] amag;
    logic [DATA_W-1:0] bmag;
    logic [2*DATA_W-1:0] st;
    state_next = state_reg;
    op_next    = op_reg;
    a_next     = a_reg;
    b_next     = b_reg;
    sgn_next   = sgn_reg;
    part_next  = part_reg;
    acc_next   = acc_reg;
    cnt_next   = cnt_reg;
    iter_next  = iter_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    dvs_next   = dvs_reg;
    qneg_next  = qneg_reg;
    rneg_next  = rneg_reg;
    gst_v_next = 1'b0;
    gst_next   = gst_reg;
    gpr_v_next = gst_v_reg;
    gpr_d_next = gst_reg;
    rd_v_next  = 1'b0;
    rd_d_next  = rd_d_reg;
    fin_mul    = 1'b0;
    fop        = issue_op_in;
    skip       = div_skip(source_a_operand_in, in_sgn);
    amag = (in_sgn && source_a_operand_in[31]) ? -source_a_operand_in
                                               : source_a_operand_in;
    bmag = (in_sgn && source_b_operand_in[31]) ? -source_b_operand_in
                                               : source_b_operand_in;
    st = div_step(rem_reg, quo_reg, dvs_reg);
    // no stall input: work in flight never waits on the integer pipe
    case (state_reg)
      ST_IDLE: begin
        if (go && op_product_to_acc(issue_op_in)) begin
          if (fits16) begin
            fin_mul = 1'b1;
          end else begin
            // second pass holds the array, so the next issue waits
            state_next = ST_PASS2;
            op_next    = issue_op_in;
            a_next     = source_a_operand_in;
            b_next     = source_b_operand_in;
            sgn_next   = in_sgn;
            part_next  = prod;
          end
        end else if (go && (issue_op_in == OP_DIV ||
                            issue_op_in == OP_DIVU)) begin
          // first quotient bit is taken on the issue edge itself
          st         = div_step('0, amag << skip, bmag);
          rem_next   = st[2*DATA_W-1:DATA_W];
          quo_next   = st[DATA_W-1:0];
          dvs_next   = bmag;
          iter_next  = DIV_FULL_ITER - skip - 6'h01;
          cnt_next   = div_rep(skip) - 6'h01;
          qneg_next  = in_sgn & (source_a_operand_in[31] ^
                                 source_b_operand_in[31]);
          rneg_next  = in_sgn & source_a_operand_in[31];
          state_next = ST_DIV;
        end else if (go && issue_op_in == OP_READ_TOP) begin
          rd_v_next = 1'b1;
          rd_d_next = acc_reg[ACC_W-1:DATA_W];
        end else if (go && issue_op_in == OP_READ_BOTTOM) begin
          rd_v_next = 1'b1;
          rd_d_next = acc_reg[DATA_W-1:0];
        end
      end
      ST_PASS2: begin
        fin_mul    = 1'b1;
        fop        = op_reg;
        state_next = ST_IDLE;
      end
      ST_DIV: begin
        if (iter_reg != '0) begin
          rem_next  = st[2*DATA_W-1:DATA_W];
          quo_next  = st[DATA_W-1:0];
          iter_next = iter_reg - 6'h01;
        end else begin
          st = {rem_reg, quo_reg};
        end
        cnt_next = cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          acc_next = {rneg_reg ? -st[2*DATA_W-1:DATA_W]
                               : st[2*DATA_W-1:DATA_W],
                      qneg_reg ? -st[DATA_W-1:0]
                               : st[DATA_W-1:0]};
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (fin_mul) begin
      case (fop)
        OP_ACC_ADD, OP_ACC_ADDU: acc_next = acc_reg + prod_full;
        OP_ACC_SUB, OP_ACC_SUBU: acc_next = acc_reg - prod_full;
        OP_MUL_GPR: begin
          gst_v_next = 1'b1;
          gst_next   = prod_full[DATA_W-1:0];
        end
        default: acc_next = prod_full;
      endcase
    end
    stall_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NONE;
      a_reg     <= '0;
      b_reg     <= '0;
      sgn_reg   <= 1'b0;
      part_reg  <= '0;
      acc_reg   <= '0;
      cnt_reg   <= '0;
      iter_reg  <= '0;
      rem_reg   <= '0;
      quo_reg   <= '0;
      dvs_reg   <= '0;
      qneg_reg  <= 1'b0;
      rneg_reg  <= 1'b0;
      gst_v_reg <= 1'b0;
      gst_reg   <= '0;
      gpr_v_reg <= 1'b0;
      gpr_d_reg <= '0;
      rd_v_reg  <= 1'b0;
      rd_d_reg  <= '0;
      stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      a_reg     <= a_next;
      b_reg     <= b_next;
      sgn_reg   <= sgn_next;
      part_reg  <= part_next;
      acc_reg   <= acc_next;
      cnt_reg   <= cnt_next;
      iter_reg  <= iter_next;
      rem_reg   <= rem_next;
      quo_reg   <= quo_next;
      dvs_reg   <= dvs_next;
      qneg_reg  <= qneg_next;
      rneg_reg  <= rneg_next;
      gst_v_reg <= gst_v_next;
      gst_reg   <= gst_next;
      gpr_v_reg <= gpr_v_next;
      gpr_d_reg <= gpr_d_next;
      rd_v_reg  <= rd_v_next;
      rd_d_reg  <= rd_d_next;
      stall_reg <= stall_next;
    end
  end

  assign stall_out      = stall_reg;
  assign acc_top_out    = acc_reg[ACC_W-1:DATA_W];
  assign acc_bottom_out = acc_reg[DATA_W-1:0];
  assign gpr_valid_out  = gpr_v_reg;
  assign gpr_data_out   = gpr_d_reg;
  assign read_valid_out = rd_v_reg;
  assign read_data_out  = rd_d_reg;

  // checks: expected values from plain operators, not the array
  logic signed [ACC_W-1:0] exp_s;
  logic                    take_short;
  assign exp_s = $signed({{DATA_W{source_a_operand_in[31]}},
                          source_a_operand_in}) *
                 $signed({{DATA_W{source_b_operand_in[31]}},
                          source_b_operand_in});
  assign take_short = go && op_product_to_acc(issue_op_in) && fits16;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_pass2_stall: assert property (
    go && op_product_to_acc(issue_op_in) && !fits16 |=> stall_out ##1 !stall_out)
    else $error("two-pass multiply not interlocked for one cycle");
  chk_short_rate: assert property (
    take_short |=> !stall_out)
    else $error("short multiply blocked the next issue");
  chk_prod_acc: assert property (
    take_short && issue_op_in == OP_PROD
    |=> {acc_top_out, acc_bottom_out} == $past(exp_s))
    else $error("signed product wrong in accumulator pair");
  chk_acc_add: assert property (
    take_short && issue_op_in == OP_ACC_ADD
    |=> {acc_top_out, acc_bottom_out} ==
        $past({acc_top_out, acc_bottom_out}) + $past(exp_s))
    else $error("accumulate-add result wrong");
  chk_acc_sub: assert property (
    take_short && issue_op_in == OP_ACC_SUB
    |=> {acc_top_out, acc_bottom_out} ==
        $past({acc_top_out, acc_bottom_out}) - $past(exp_s))
    else $error("accumulate-sub result wrong");
  chk_gpr_latency: assert property (
    take_short && issue_op_in == OP_MUL_GPR && !gst_v_reg
    |=> !gpr_valid_out ##1 gpr_valid_out &&
        gpr_data_out == $past(exp_s[DATA_W-1:0], 2))
    else $error("register multiply latency or data wrong");
  chk_div8_busy: assert property (
    go && issue_op_in == OP_DIVU && ~|source_a_operand_in[31:8]
    |=> stall_out [*8] ##1 stall_out ##1 stall_out ##1 !stall_out)
    else $error("8-bit divide repeat rate wrong");
  chk_div8_result: assert property (
    go && issue_op_in == OP_DIVU && ~|source_a_operand_in[31:8] &&
    source_b_operand_in != '0
    |-> ##11 acc_bottom_out == $past(source_a_operand_in /
                                     source_b_operand_in, 11) &&
        acc_top_out == $past(source_a_operand_in %
                             source_b_operand_in, 11))
    else $error("unsigned divide quotient or remainder wrong");
  chk_div32_busy: assert property (
    go && issue_op_in == OP_DIVU && |source_a_operand_in[31:24]
    |=> ##30 stall_out ##1 !stall_out)
    else $error("32-bit divide repeat rate wrong");
  chk_read_top: assert property (
    go && issue_op_in == OP_READ_TOP
    |=> read_valid_out && read_data_out == $past(acc_top_out))
    else $error("read of accumulator top wrong");

  cov_two_pass_add: cover property (
    go && issue_op_in == OP_ACC_ADD && !fits16 ##2 !stall_out);
  cov_signed_div: cover property (
    go && issue_op_in == OP_DIV && source_a_operand_in[31]);
  cov_back_to_back: cover property (take_short ##1 take_short);
endmodule : amu_unit

`default_nettype wire

// *** amu_host_model.sv ***
// host model: integer pipe side issuing operations to the arith unit
`default_nettype none

module amu_host_model
  import amu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              stall_in,
  output var  logic              issue_valid_out,
  output var  amu_op_t           issue_op_out,
  output var  logic [DATA_W-1:0] source_a_operand_out,
  output var  logic [DATA_W-1:0] source_b_operand_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    issue_valid_out      = 1'b0;
    issue_op_out         = OP_NONE;
    source_a_operand_out = 32'h0;
    source_b_operand_out = 32'h0;
  end

  // request held whole until a cycle with stall low lets the edge take it
  task automatic issue(input amu_op_t op, input logic [DATA_W-1:0] a,
                       input logic [DATA_W-1:0] b, output int waits);
    @(negedge clk_in);
    issue_valid_out      = 1'b1;
    issue_op_out         = op;
    source_a_operand_out = a;
    source_b_operand_out = b;
    waits = 0;
    while (stall_in !== 1'b0 && waits < 100) begin
      @(negedge clk_in);
      waits++;
    end
    @(posedge clk_in);
  endtask : issue

  // released operands are scrambled so stale values cannot be relied on
  task automatic idle();
    @(negedge clk_in);
    issue_valid_out      = 1'b0;
    source_a_operand_out = ~source_a_operand_out;
    source_b_operand_out = ~source_b_operand_out;
  endtask : idle
endmodule : amu_host_model

`default_nettype wire

// *** multiply_divide_unit_test.sv ***
// self-checking bench for the arith unit with its host model
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module multiply_divide_unit_test
  import amu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in;
  logic              rst_n_in;
  logic              issue_valid;
  amu_op_t           issue_op;
  logic [DATA_W-1:0] op_a;
  logic [DATA_W-1:0] op_b;
  logic              stall;
  logic [DATA_W-1:0] acc_top;
  logic [DATA_W-1:0] acc_bottom;
  logic              gpr_valid;
  logic [DATA_W-1:0] gpr_data;
  logic              read_valid;
  logic [DATA_W-1:0] read_data;
  logic [ACC_W-1:0]  exp_acc;
  int                miscompares = 0;
  int                comparisons = 0;
  int                waits;

  amu_unit u_amu_unit (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .issue_valid_in      (issue_valid),
    .issue_op_in         (issue_op),
    .source_a_operand_in (op_a),
    .source_b_operand_in (op_b),
    .stall_out           (stall),
    .acc_top_out         (acc_top),
    .acc_bottom_out      (acc_bottom),
    .gpr_valid_out       (gpr_valid),
    .gpr_data_out        (gpr_data),
    .read_valid_out      (read_valid),
    .read_data_out       (read_data)
  );

  amu_host_model u_amu_host_model (
    .clk_in               (clk_in),
    .stall_in             (stall),
    .issue_valid_out      (issue_valid),
    .issue_op_out         (issue_op),
    .source_a_operand_out (op_a),
    .source_b_operand_out (op_b)
  );

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [ACC_W-1:0] prod(input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b, input logic sgn);
    logic [ACC_W-1:0] ea;
    logic [ACC_W-1:0] eb;
    ea = sgn ? {{32{a[31]}}, a} : {32'h0, a};
    eb = sgn ? {{32{b[31]}}, b} : {32'h0, b};
    prod = ea * eb;
  endfunction : prod

  function automatic logic [ACC_W-1:0] div_exp(input logic sgn,
      input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    if (sgn) begin
      div_exp = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
    end else begin
      div_exp = {a % b, a / b};
    end
  endfunction : div_exp

  task automatic check_acc(input logic [ACC_W-1:0] e);
    `CHK("acc_top", e[63:32], acc_top)
    `CHK("acc_bottom", e[31:0], acc_bottom)
  endtask : check_acc

  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset_state();
    @(negedge clk_in);
    check_acc(64'h0);
    `CHK("stall", 1'b0, stall)
    `CHK("gpr strobe", 1'b0, gpr_valid)
    `CHK("read strobe", 1'b0, read_valid)
  endtask : t_reset_state

  // short issues every edge, then a second long one must wait one edge
  task automatic t_back_to_back();
    u_amu_host_model.issue(OP_PROD, 32'h00000003, 32'hffff8000, waits);
    u_amu_host_model.issue(OP_PROD, 32'h12345678, 32'h9abcdef0, waits);
    `CHK("short wait", 0, waits)
    u_amu_host_model.issue(OP_PRODU, 32'hffffffff, 32'hffffffff, waits);
    `CHK("long wait", 1, waits)
    u_amu_host_model.idle();
    `CHK("stall", 1'b1, stall)
    check_acc(prod(32'h12345678, 32'h9abcdef0, 1'b1));
    @(negedge clk_in);
    exp_acc = prod(32'hffffffff, 32'hffffffff, 1'b0);
    check_acc(exp_acc);
  endtask : t_back_to_back

  task automatic t_acc_op(input amu_op_t op, input logic [DATA_W-1:0] a,
                          input logic [DATA_W-1:0] b, input logic long_b);
    logic             sgn;
    logic [ACC_W-1:0] old;
    logic [ACC_W-1:0] p;
    sgn = (op == OP_PROD || op == OP_ACC_ADD || op == OP_ACC_SUB);
    p = prod(a, b, sgn);
    old = exp_acc;
    case (op)
      OP_ACC_ADD, OP_ACC_ADDU: exp_acc = exp_acc + p;
      OP_ACC_SUB, OP_ACC_SUBU: exp_acc = exp_acc - p;
      default: exp_acc = p;
    endcase
    u_amu_host_model.issue(op, a, b, waits);
    u_amu_host_model.idle();
    `CHK("stall", long_b, stall)
    if (long_b) begin
      check_acc(old);
      @(negedge clk_in);
    end
    check_acc(exp_acc);
  endtask : t_acc_op

  task automatic t_mul_gpr(input logic [DATA_W-1:0] a,
                           input logic [DATA_W-1:0] b, input int lat);
    logic [ACC_W-1:0] p;
    p = prod(a, b, 1'b1);
    u_amu_host_model.issue(OP_MUL_GPR, a, b, waits);
    u_amu_host_model.idle();
    repeat (lat - 1) begin
      `CHK("gpr strobe", 1'b0, gpr_valid)
      @(negedge clk_in);
    end
    `CHK("gpr strobe", 1'b1, gpr_valid)
    `CHK("gpr data", p[31:0], gpr_data)
    check_acc(exp_acc);
    @(negedge clk_in);
    `CHK("gpr strobe", 1'b0, gpr_valid)
  endtask : t_mul_gpr

  // a move issued right behind the divide is held until the divide ends
  task automatic t_divide(input amu_op_t op, input logic [DATA_W-1:0] a,
                          input logic [DATA_W-1:0] b, input int rep,
                          input amu_op_t rd);
    logic [DATA_W-1:0] rd_exp;
    exp_acc = div_exp(op == OP_DIV, a, b);
    rd_exp = (rd == OP_READ_TOP) ? exp_acc[63:32] : exp_acc[31:0];
    u_amu_host_model.issue(op, a, b, waits);
    u_amu_host_model.issue(rd, 32'h0, 32'h0, waits);
    `CHK("div wait", rep - 1, waits)
    u_amu_host_model.idle();
    `CHK("read strobe", 1'b1, read_valid)
    `CHK("read data", rd_exp, read_data)
    check_acc(exp_acc);
    @(negedge clk_in);
    `CHK("read strobe", 1'b0, read_valid)
  endtask : t_divide

  // no further issue: the divide must still run to its end on its own
  task automatic t_unattended();
    int cnt;
    cnt = 0;
    exp_acc = div_exp(1'b1, 32'h80000001, 32'h00000003);
    u_amu_host_model.issue(OP_DIV, 32'h80000001, 32'h00000003, waits);
    u_amu_host_model.idle();
    repeat (31) begin
      if (stall === 1'b1) cnt++;
      @(negedge clk_in);
    end
    `CHK("div busy", 31, cnt)
    `CHK("stall", 1'b0, stall)
    check_acc(exp_acc);
  endtask : t_unattended

  task automatic t_ignored();
    logic [3:0] codes [5] = '{4'h0, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (codes[i]) begin
      u_amu_host_model.issue(amu_op_t'(codes[i]), 32'hffffffff,
                             32'h7fffffff, waits);
    end
    u_amu_host_model.idle();
    @(negedge clk_in);
    check_acc(exp_acc);
    `CHK("read strobe", 1'b0, read_valid)
    `CHK("gpr strobe", 1'b0, gpr_valid)
  endtask : t_ignored

  initial begin
    rst_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset_state();
    rst_n_in = 1'b1;
    t_back_to_back();
    t_acc_op(OP_PROD, 32'hfffffffb, 32'h00001234, 1'b0);
    t_acc_op(OP_ACC_ADD, 32'h80000000, 32'h00007fff, 1'b0);
    t_acc_op(OP_ACC_SUB, 32'h00012345, 32'hfffe0000, 1'b1);
    t_acc_op(OP_ACC_ADDU, 32'hffffffff, 32'h00008000, 1'b0);
    t_acc_op(OP_ACC_SUBU, 32'h0000ffff, 32'h00010000, 1'b1);
    t_acc_op(OP_ACC_SUB, 32'h00000100, 32'hffffff00, 1'b0);
    t_mul_gpr(32'h00000007, 32'hfffffffd, 2);
    t_mul_gpr(32'h00010001, 32'h00010001, 3);
    t_divide(OP_DIVU, 32'h00000064, 32'h00000007, 11, OP_READ_BOTTOM);
    t_divide(OP_DIV, 32'hffffff9c, 32'h00000007, 11, OP_READ_TOP);
    t_divide(OP_DIV, 32'h00000080, 32'h00000005, 18, OP_READ_BOTTOM);
    t_divide(OP_DIVU, 32'h00001234, 32'h00000007, 18, OP_READ_TOP);
    t_divide(OP_DIV, 32'hffedcba9, 32'hfffffffd, 25, OP_READ_TOP);
    t_divide(OP_DIVU, 32'h00ff0000, 32'h00000009, 25, OP_READ_BOTTOM);
    t_divide(OP_DIVU, 32'h12345678, 32'h00000007, 32, OP_READ_BOTTOM);
    t_unattended();
    t_ignored();
    report_and_stop();
  end

  // whole sequence needs about 235 cycles; over ten times that is a hang
  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule : multiply_divide_unit_test

`undef CHK
`default_nettype wire
